// ---- hw/sbc_pkg.sv ----
/*
 sbc_pkg: types shared by the serial register bank of the supply controller.
 assumes: constants live in sbc_map.svh; this package holds types only.
*/
package sbc_pkg;

   // access class of one register
   typedef enum logic [1:0] {
      SBC_RW,
      SBC_RC,
      SBC_RO
   } sbc_kind_t;

   // one row of the register table
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] rmask;
      logic [7:0] hmask;
      logic [7:0] keep;
      sbc_kind_t  kind;
   } sbc_info_t;

   // request from chip logic to change hardware-owned control bits
   typedef struct packed {
      logic       valid;
      logic [6:0] addr;
      logic [7:0] mask;
      logic [7:0] data;
   } sbc_hw_upd_t;

   typedef logic [18:0][7:0] sbc_ctrl_bank_t;
   typedef logic [9:0][7:0]  sbc_stat_bank_t;

endpackage

// ---- hw/sbc_map.svh ----
/*
 sbc_map.svh: register map, masks, restart keep masks and frame counts.
 assumes: included ahead of the modules that use it, after sbc_pkg has been compiled.
*/
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH

`define SBC_NREG        31
`define SBC_NCTRL       19
`define SBC_FIRST_RC    19
`define SBC_NRC         10
`define SBC_IDX_LVL     29
`define SBC_IDX_ID      30
`define SBC_IDX_MSC     0
`define SBC_IDX_HW      1
`define SBC_FRAME_BITS  5'h10
`define SBC_HDR_LAST    5'h07
`define SBC_HDR_BITS    5'h08
`define SBC_CNT_OVER    5'h11
`define SBC_CNT_ZERO    5'h00
`define SBC_CNT_ONE     5'h01
`define SBC_RW_BIT      7
`define SBC_POR_VAL     8'h00
`define SBC_KEEP_MSC    8'h23
`define SBC_KEEP_HW     8'hd9
`define SBC_MODE_HI     7
`define SBC_MODE_LO     6
`define SBC_MODE_SOFT   2'h3
`define SBC_FAM_ID_DFLT 8'h5a
`define SBC_SYNC_INIT   3'h2

// addr, readable mask, hardware mask, restart keep mask, kind
`define SBC_R_MSC  '{7'h01, 8'hff, 8'hfc, 8'h23, sbc_pkg::SBC_RW}
`define SBC_R_HWC  '{7'h02, 8'hfb, 8'h20, 8'hd9, sbc_pkg::SBC_RW}
`define SBC_R_SUP  '{7'h03, 8'hf7, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_TRA  '{7'h04, 8'hfb, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_TRB  '{7'h05, 8'h23, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_WKA  '{7'h06, 8'hc4, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_WKB  '{7'h07, 8'ha7, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_WPU  '{7'h08, 8'h3f, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_WFL  '{7'h09, 8'h3f, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_CTA  '{7'h0c, 8'h77, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_CTB  '{7'h0d, 8'h77, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_SSD  '{7'h10, 8'h70, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_HSA  '{7'h14, 8'h77, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_HSB  '{7'h15, 8'h77, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_PFO  '{7'h17, 8'hff, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_DCA  '{7'h18, 8'hff, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_DCB  '{7'h19, 8'hff, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_MFS  '{7'h1c, 8'h05, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_SCR  '{7'h1e, 8'hff, 8'h00, 8'hff, sbc_pkg::SBC_RW}
`define SBC_R_SSB  '{7'h40, 8'h5f, 8'h00, 8'hff, sbc_pkg::SBC_RC}
`define SBC_R_SSA  '{7'h41, 8'hff, 8'h00, 8'hff, sbc_pkg::SBC_RC}
`define SBC_R_THS  '{7'h42, 8'h07, 8'h00, 8'hff, sbc_pkg::SBC_RC}
`define SBC_R_DFS  '{7'h43, 8'hcf, 8'h00, 8'hff, sbc_pkg::SBC_RC}
`define SBC_R_TSA  '{7'h44, 8'h67, 8'h00, 8'hff, sbc_pkg::SBC_RC}
`define SBC_R_TSB  '{7'h45, 8'h06, 8'h00, 8'hff, sbc_pkg::SBC_RC}
`define SBC_R_WSA  '{7'h46, 8'hef, 8'h00, 8'hff, sbc_pkg::SBC_RC}
`define SBC_R_WSB  '{7'h47, 8'h30, 8'h00, 8'hff, sbc_pkg::SBC_RC}
`define SBC_R_HOV  '{7'h54, 8'h0f, 8'h00, 8'hff, sbc_pkg::SBC_RC}
`define SBC_R_HOL  '{7'h55, 8'h0f, 8'h00, 8'hff, sbc_pkg::SBC_RC}
`define SBC_R_WLV  '{7'h48, 8'hf7, 8'h00, 8'hff, sbc_pkg::SBC_RO}
`define SBC_R_FPI  '{7'h7e, 8'hff, 8'h00, 8'hff, sbc_pkg::SBC_RO}

`endif

// ---- hw/sbc_sync.sv ----
/*
 sbc_sync: two-flop synchroniser for a group of independent pin levels.
 assumes: each bit is a slow level; no bit relation is kept across the group.
*/
`timescale 1ns/1ps
module sbc_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input  wire logic             mclk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] q_reg;

   // first stage feeds only the second stage
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= INIT;
         q_reg    <= INIT;
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;
endmodule // sbc_sync

// ---- hw/sbc_regbank.sv ----
/*
 sbc_regbank: serial-reachable control/status register bank of the supply controller.
 assumes: spi pins come from an external master (mode 0, clock idle low) and are
 oversampled by mclk, so sclk must stay below about mclk/8; chip logic drives
 restart, soft_reset, hw_upd and stat_set on mclk.
*/
`timescale 1ns/1ps
`include "sbc_map.svh"
module sbc_regbank #(
   parameter logic [7:0] FAMILY_PRODUCT_ID = `SBC_FAM_ID_DFLT  // arbitrary value
) (
   input  wire logic                   mclk,
   input  wire logic                   rst_b,
   input  wire logic                   spi_sclk,
   input  wire logic                   spi_csn_b,
   input  wire logic                   spi_mosi,
   output logic                        spi_miso,
   output logic                        spi_miso_oe_b,
   input  wire logic                   soft_reset,
   input  wire logic                   restart,
   input  wire sbc_pkg::sbc_hw_upd_t   hw_upd,
   input  wire sbc_pkg::sbc_stat_bank_t stat_set,
   input  wire logic [7:0]             wake_level,
   output sbc_pkg::sbc_ctrl_bank_t     ctrl_bank,
   output logic                        soft_reset_req,
   output logic                        frame_error
);

   localparam sbc_pkg::sbc_info_t INFO [`SBC_NREG] = '{
      `SBC_R_MSC, `SBC_R_HWC, `SBC_R_SUP, `SBC_R_TRA, `SBC_R_TRB,
      `SBC_R_WKA, `SBC_R_WKB, `SBC_R_WPU, `SBC_R_WFL, `SBC_R_CTA,
      `SBC_R_CTB, `SBC_R_SSD, `SBC_R_HSA, `SBC_R_HSB, `SBC_R_PFO,
      `SBC_R_DCA, `SBC_R_DCB, `SBC_R_MFS, `SBC_R_SCR, `SBC_R_SSB,
      `SBC_R_SSA, `SBC_R_THS, `SBC_R_DFS, `SBC_R_TSA, `SBC_R_TSB,
      `SBC_R_WSA, `SBC_R_WSB, `SBC_R_HOV, `SBC_R_HOL, `SBC_R_WLV,
      `SBC_R_FPI
   };

   logic [2:0] pin_s;
   logic       sclk_s;
   logic       csn_s;
   logic       mosi_s;
   logic       sclk_d_reg;
   logic       csn_d_reg;
   logic       rise;
   logic       fall;
   logic       cs_start;
   logic       cs_end;
   logic       active;
   logic [4:0] bit_cnt_reg;
   logic [7:0] rx_reg;
   logic [7:0] hdr_reg;
   logic [7:0] tx_reg;
   logic       bad_frame_reg;
   logic       soft_req_reg;
   logic       oe_b_reg;
   logic       rd_hit;
   logic [4:0] rd_idx;
   logic [7:0] rd_data;
   logic       wr_fire;
   logic       wr_is_rw;
   logic [7:0] regs_reg  [`SBC_NREG];
   logic [7:0] regs_next [`SBC_NREG];

   // pins are asynchronous to mclk
   sbc_sync #(
      .WIDTH (3),
      .INIT  (`SBC_SYNC_INIT)
   ) i_sbc_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     ({spi_sclk, spi_csn_b, spi_mosi}),
      .q     (pin_s)
   );

   assign sclk_s = pin_s[2];
   assign csn_s  = pin_s[1];
   assign mosi_s = pin_s[0];

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_d_reg <= 1'b0;
         csn_d_reg  <= 1'b1;
      end else begin
         sclk_d_reg <= sclk_s;
         csn_d_reg  <= csn_s;
      end
   end

   assign active   = ~csn_s;
   assign rise     = sclk_s & ~sclk_d_reg & active;
   assign fall     = ~sclk_s & sclk_d_reg & active;
   assign cs_start = ~csn_s & csn_d_reg;
   assign cs_end   = csn_s & ~csn_d_reg;

   // bit counter saturates one past a full frame so long frames are caught
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bit_cnt_reg <= `SBC_CNT_ZERO;
      end else if (cs_start) begin
         bit_cnt_reg <= `SBC_CNT_ZERO;
      end else if (rise && bit_cnt_reg != `SBC_CNT_OVER) begin
         bit_cnt_reg <= bit_cnt_reg + `SBC_CNT_ONE;
      end
   end

   // msb first; the header byte is frozen after its eighth bit
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rx_reg  <= 8'h00;
         hdr_reg <= 8'h00;
      end else if (rise) begin
         rx_reg <= {rx_reg[6:0], mosi_s};
         if (bit_cnt_reg == `SBC_HDR_LAST) begin
            hdr_reg <= {rx_reg[6:0], mosi_s};
         end
      end
   end

   // one address, one whole register
   always_comb begin
      rd_hit = 1'b0;
      rd_idx = 5'h00;
      for (int i = 0; i < `SBC_NREG; i++) begin
         if (INFO[i].addr == hdr_reg[6:0]) begin
            rd_hit = 1'b1;
            rd_idx = 5'(i);
         end
      end
   end

   always_comb begin
      rd_data = 8'h00;
      if (rd_hit) begin
         if (rd_idx == 5'(`SBC_IDX_LVL)) begin
            rd_data = wake_level;
         end else if (rd_idx == 5'(`SBC_IDX_ID)) begin
            rd_data = FAMILY_PRODUCT_ID;
         end else begin
            rd_data = regs_reg[rd_idx];
         end
         rd_data = rd_data & INFO[rd_idx].rmask;
      end
   end

   // commit only on a clean end of a complete frame with the write flag set
   assign wr_fire  = cs_end && bit_cnt_reg == `SBC_FRAME_BITS && hdr_reg[`SBC_RW_BIT] && rd_hit;
   assign wr_is_rw = INFO[rd_idx].kind == sbc_pkg::SBC_RW;

   always_comb begin
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < `SBC_NREG; i++) begin
         regs_next[i] = regs_reg[i];
         if (INFO[i].kind == sbc_pkg::SBC_RW) begin
            if (wr_fire && rd_idx == 5'(i)) begin
               regs_next[i] = rx_reg & INFO[i].rmask;
            end
            m = hw_upd.mask & INFO[i].hmask;
            if (hw_upd.valid && hw_upd.addr == INFO[i].addr) begin
               regs_next[i] = (regs_next[i] & ~m) | (hw_upd.data & m);
            end
         end else if (INFO[i].kind == sbc_pkg::SBC_RC) begin
            if (wr_fire && rd_idx == 5'(i)) begin
               regs_next[i] = 8'h00;
            end
            // a status event in the clearing cycle survives
            regs_next[i] = regs_next[i] | (stat_set[i - `SBC_FIRST_RC] & INFO[i].rmask);
         end
         if (restart) begin
            regs_next[i] = regs_reg[i] & INFO[i].keep;
         end
      end
   end

   // read-only entries are never written; their value comes from the wake_level port and the FAMILY_PRODUCT_ID parameter
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < `SBC_NREG; i++) begin
            regs_reg[i] <= `SBC_POR_VAL;
         end
      end else if (soft_reset) begin
         for (int i = 0; i < `SBC_NREG; i++) begin
            regs_reg[i] <= `SBC_POR_VAL;
         end
      end else begin
         for (int i = 0; i < `SBC_NREG; i++) begin
            regs_reg[i] <= regs_next[i];
         end
      end
   end

   always_comb begin
      for (int i = 0; i < `SBC_NCTRL; i++) begin
         ctrl_bank[i] = regs_reg[i];
      end
   end

   // first byte out carries the previous frame's length error
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tx_reg <= 8'h00;
      end else if (cs_start) begin
         tx_reg <= {7'h00, bad_frame_reg};
      end else if (fall) begin
         if (bit_cnt_reg == `SBC_HDR_BITS) begin
            tx_reg <= rd_data;
         end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bad_frame_reg <= 1'b0;
      end else if (cs_end) begin
         bad_frame_reg <= bit_cnt_reg != `SBC_FRAME_BITS;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         soft_req_reg <= 1'b0;
      end else begin
         soft_req_reg <= wr_fire && rd_idx == 5'(`SBC_IDX_MSC)
                         && rx_reg[`SBC_MODE_HI:`SBC_MODE_LO] == `SBC_MODE_SOFT;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         oe_b_reg <= 1'b1;
      end else begin
         oe_b_reg <= csn_s;
      end
   end

   assign spi_miso       = tx_reg[7];
   assign spi_miso_oe_b  = oe_b_reg;
   assign soft_reset_req = soft_req_reg;
   assign frame_error    = bad_frame_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   sequence s_hdr_load;
      fall && bit_cnt_reg == `SBC_HDR_BITS;
   endsequence

   sequence s_frame_write;
      cs_end && bit_cnt_reg == `SBC_FRAME_BITS && hdr_reg[`SBC_RW_BIT] && rd_hit;
   endsequence

   sequence s_quiet;
      !restart && !soft_reset && !hw_upd.valid;
   endsequence

   a_short_frame: assert property (cs_end && bit_cnt_reg != `SBC_FRAME_BITS |-> !wr_fire ##1 bad_frame_reg)
      else $error("short or long frame was committed");

   a_read_only: assert property (cs_end && bit_cnt_reg == `SBC_FRAME_BITS && !hdr_reg[`SBC_RW_BIT] and s_quiet
                                 |=> $stable(ctrl_bank) && !bad_frame_reg)
      else $error("read frame changed a register");

   a_write_stores: assert property ((s_frame_write and s_quiet) ##0 wr_is_rw
                                    |=> regs_reg[$past(rd_idx)] == ($past(rx_reg) & INFO[$past(rd_idx)].rmask))
      else $error("write frame did not store data");

   a_reserved_zero: assert property (rd_hit |-> (rd_data & ~INFO[rd_idx].rmask) == 8'h00)
      else $error("reserved bit read as one");

   a_reset_value: assert property (soft_reset |=> ctrl_bank == '0 && regs_reg[`SBC_FIRST_RC] == `SBC_POR_VAL)
      else $error("soft reset did not load defaults");

   a_restart_keep: assert property (restart && !soft_reset
                                    |=> regs_reg[`SBC_IDX_MSC] == ($past(regs_reg[`SBC_IDX_MSC]) & `SBC_KEEP_MSC)
                                        && regs_reg[`SBC_IDX_HW] == ($past(regs_reg[`SBC_IDX_HW]) & `SBC_KEEP_HW))
      else $error("restart values wrong");

   a_set_wins: assert property (stat_set[0][0] && !restart && !soft_reset |=> regs_reg[`SBC_FIRST_RC][0])
      else $error("status event lost");

   a_ctrl_stable: assert property (!wr_fire and s_quiet |=> $stable(ctrl_bank))
      else $error("control bits changed on their own");

   a_echo_before: assert property (s_hdr_load |=> tx_reg == $past(rd_data) ##1 1'b1)
      else $error("echo byte not the pre-write contents");

   a_first_byte: assert property (cs_start |=> tx_reg == {7'h00, $past(bad_frame_reg)})
      else $error("first byte does not carry the frame error flag");

   a_error_held: assert property (!cs_end |=> $stable(bad_frame_reg))
      else $error("frame error flag changed outside a frame end");

   a_count_held: assert property (bit_cnt_reg == `SBC_CNT_OVER && !cs_start |=> bit_cnt_reg == `SBC_CNT_OVER)
      else $error("bit counter left its saturation value");

   a_header_frozen: assert property (bit_cnt_reg != `SBC_HDR_LAST |=> $stable(hdr_reg))
      else $error("header byte changed after its eighth bit");

   a_msb_first: assert property (rise |=> rx_reg == {$past(rx_reg[6:0]), $past(mosi_s)})
      else $error("receive shift is not msb first");

   a_soft_request: assert property (s_frame_write ##0 (rd_idx == 5'(`SBC_IDX_MSC)
                                    && rx_reg[`SBC_MODE_HI:`SBC_MODE_LO] == `SBC_MODE_SOFT) |=> soft_reset_req)
      else $error("mode write did not request a soft reset");

   a_status_clear: assert property ((s_frame_write and s_quiet) ##0 (INFO[rd_idx].kind == sbc_pkg::SBC_RC
                                    && stat_set == '0) |=> regs_reg[$past(rd_idx)] == 8'h00)
      else $error("write frame did not clear a status register");

   a_ident_read: assert property (rd_hit && rd_idx == 5'(`SBC_IDX_ID) |-> rd_data == FAMILY_PRODUCT_ID)
      else $error("identifier read wrong");

   a_level_read: assert property (rd_hit && rd_idx == 5'(`SBC_IDX_LVL)
                                  |-> rd_data == (wake_level & INFO[`SBC_IDX_LVL].rmask))
      else $error("pin level read wrong");

   a_unmapped_zero: assert property (!rd_hit |-> rd_data == 8'h00)
      else $error("unmapped address read as nonzero");

   a_hw_owned: assert property (hw_upd.valid && hw_upd.addr == INFO[`SBC_IDX_MSC].addr
                                && !restart && !soft_reset
                                |=> ((regs_reg[`SBC_IDX_MSC] ^ $past(hw_upd.data)) & $past(hw_upd.mask)
                                     & INFO[`SBC_IDX_MSC].hmask) == 8'h00)
      else $error("hardware update of owned bits lost");

   a_oe_follows_select: assert property (1'b1 |=> spi_miso_oe_b == $past(csn_s))
      else $error("miso enable does not follow chip select");

endmodule // sbc_regbank

// ---- test/sbc_host.sv ----
/*
 sbc_host: behavioural serial master that sends one register frame at a time.
 assumes: the bank oversamples these pins with a clock at least eight times faster than sclk.
*/
`timescale 1ns/1ps
module sbc_host (
   output logic     spi_sclk,
   output logic     spi_csn_b,
   output logic     spi_mosi,
   input wire logic spi_miso
);
   initial begin
      spi_sclk  = 1'b0;
      spi_csn_b = 1'b1;
      spi_mosi  = 1'b0;
   end

   // nbits other than 16 only to provoke a framing fault
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = '0;
      #7;
      spi_csn_b = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         spi_mosi = tx[15 - (i % 16)];
         #100;
         spi_sclk = 1'b1;
         rx = {rx[14:0], spi_miso};
         #100;
         spi_sclk = 1'b0;
      end
      #100;
      spi_csn_b = 1'b1;
      // no pull on the line, so a released mosi must not keep looking like data
      spi_mosi = ~spi_mosi;
      #200;
   endtask
endmodule // sbc_host

// ---- test/sbc_regbank_tb.sv ----
/*
 sbc_regbank_tb: frame-level tests of the register bank through the serial host model.
 assumes: the register table macros of sbc_map.svh; commits land within ten mclk of csn rising.
*/
`timescale 1ns/1ps
module sbc_regbank_tb;
`include "sbc_map.svh"
   localparam logic [7:0] FPI = 8'h3c;  // arbitrary identifier value
   logic                    mclk, rst_b, spi_sclk, spi_csn_b, spi_mosi, spi_miso, spi_miso_oe_b;
   logic                    soft_reset, restart, soft_reset_req, frame_error;
   sbc_pkg::sbc_hw_upd_t    hw_upd;
   sbc_pkg::sbc_stat_bank_t stat_set;
   sbc_pkg::sbc_ctrl_bank_t ctrl_bank;
   logic [7:0]              wake_level, b1, b2;
   logic [7:0]              ev [19];
   int                      mismatches, total_checks, soft_reqs, oe_cycles;
   sbc_pkg::sbc_info_t      tbl [31] = '{`SBC_R_MSC, `SBC_R_HWC, `SBC_R_SUP, `SBC_R_TRA, `SBC_R_TRB,
      `SBC_R_WKA, `SBC_R_WKB, `SBC_R_WPU, `SBC_R_WFL, `SBC_R_CTA, `SBC_R_CTB, `SBC_R_SSD, `SBC_R_HSA,
      `SBC_R_HSB, `SBC_R_PFO, `SBC_R_DCA, `SBC_R_DCB, `SBC_R_MFS, `SBC_R_SCR, `SBC_R_SSB, `SBC_R_SSA,
      `SBC_R_THS, `SBC_R_DFS, `SBC_R_TSA, `SBC_R_TSB, `SBC_R_WSA, `SBC_R_WSB, `SBC_R_HOV, `SBC_R_HOL,
      `SBC_R_WLV, `SBC_R_FPI};

   sbc_host i_sbc_host (.spi_sclk(spi_sclk), .spi_csn_b(spi_csn_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

   sbc_regbank #(.FAMILY_PRODUCT_ID(FPI)) i_sbc_regbank (
      .mclk(mclk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_csn_b(spi_csn_b), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe_b(spi_miso_oe_b), .soft_reset(soft_reset), .restart(restart),
      .hw_upd(hw_upd), .stat_set(stat_set), .wake_level(wake_level), .ctrl_bank(ctrl_bank),
      .soft_reset_req(soft_reset_req), .frame_error(frame_error));

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // sampled mid-cycle so the registered outputs have settled
   always @(negedge mclk) begin
      if (soft_reset_req === 1'b1)
         soft_reqs++;
      if (spi_miso_oe_b === 1'b0)
         oe_cycles++;
   end

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // one frame; b1 and b2 hold the two bytes shifted back
   task automatic xf(input logic w, input logic [6:0] a, input logic [7:0] d, input int n = 16);
      logic [15:0] r;
      i_sbc_host.xfer({w, a, d}, n, r);
      b1 = r[15:8];
      b2 = r[7:0];
      repeat (10) @(negedge mclk);
   endtask

   function automatic logic [7:0] pat(input int i);
      return (8'h5a ^ 8'(i * 37)) & tbl[i].rmask;
   endfunction

   task automatic pulse(input int which);
      @(negedge mclk);
      if (which == 0) restart = 1'b1;
      else soft_reset = 1'b1;
      @(negedge mclk);
      restart = 1'b0;
      soft_reset = 1'b0;
      repeat (2) @(negedge mclk);
   endtask

   initial begin
      #1_500_000;
      mismatches++;
      complete_run;
   end

   initial begin
      rst_b = 1'b0;
      soft_reset = 1'b0;
      restart = 1'b0;
      hw_upd = '0;
      stat_set = '0;
      wake_level = 8'hff;
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      repeat (4) @(negedge mclk);
      for (int i = 0; i < 31; i++) begin
         xf(1'b0, tbl[i].addr, 8'h00);
         chk("reset value", (i == 30) ? FPI : (i == 29) ? 8'hf7 : 8'h00, b2);
         chk("first byte", 8'h00, b1);
      end
      chk("soft request", 8'h00, 8'(soft_reqs));
      chk("miso enabled", 8'h01, {7'h00, oe_cycles > 0});
      chk("miso released", 8'h01, {7'h00, spi_miso_oe_b});
      $display("test reset_values done");
      // ones into reserved places on purpose, to see them read back as zero
      for (int i = 0; i < 19; i++) begin
         xf(1'b1, tbl[i].addr, 8'hff);
         chk("echo old", 8'h00, b2);
         chk("bank", tbl[i].rmask, ctrl_bank[i]);
         xf(1'b0, tbl[i].addr, 8'h00);
         chk("readback", tbl[i].rmask, b2);
      end
      for (int i = 0; i < 19; i++) begin
         xf(1'b1, tbl[i].addr, pat(i));
         chk("echo prev", tbl[i].rmask, b2);
         ev[i] = pat(i);
      end
      for (int i = 0; i < 19; i++) begin
         xf(1'b0, tbl[i].addr, 8'hff);
         chk("read data", ev[i], b2);
         chk("bank kept", ev[i], ctrl_bank[i]);
      end
      chk("soft request", 8'h01, 8'(soft_reqs));
      $display("test write_read done");
      @(negedge mclk);
      wake_level = 8'h0c;
      xf(1'b1, 7'h48, 8'hff);
      xf(1'b1, 7'h7e, 8'h00);
      xf(1'b0, 7'h48, 8'h00);
      chk("level", 8'h04, b2);
      xf(1'b0, 7'h7e, 8'h00);
      chk("ident", FPI, b2);
      xf(1'b1, 7'h00, 8'hff);
      xf(1'b0, 7'h00, 8'h00);
      chk("unmapped", 8'h00, b2);
      $display("test read_only done");
      for (int n = 15; n <= 17; n += 2) begin
         xf(1'b1, tbl[2].addr, 8'hff, n);
         chk("frame err", 8'h01, {7'h00, frame_error});
         xf(1'b0, tbl[2].addr, 8'h00);
         chk("err byte", 8'h01, b1);
         chk("no write", ev[2], b2);
      end
      xf(1'b0, tbl[2].addr, 8'h00);
      chk("err cleared", 8'h00, b1);
      $display("test framing done");
      for (int k = 0; k < 10; k++) begin
         @(negedge mclk);
         stat_set[k] = 8'hff;
         @(negedge mclk);
         stat_set[k] = 8'h00;
         xf(1'b0, tbl[19 + k].addr, 8'h00);
         chk("status", tbl[19 + k].rmask, b2);
         xf(1'b0, tbl[19 + k].addr, 8'h00);
         chk("sticky", tbl[19 + k].rmask, b2);
         xf(1'b1, tbl[19 + k].addr, 8'h00);
         chk("clear echo", tbl[19 + k].rmask, b2);
         xf(1'b0, tbl[19 + k].addr, 8'h00);
         chk("cleared", 8'h00, b2);
      end
      $display("test status done");
      @(negedge mclk);
      hw_upd = '{1'b1, 7'h01, 8'hff, 8'hff};
      @(negedge mclk);
      hw_upd = '{1'b1, 7'h02, 8'hff, 8'h00};
      @(negedge mclk);
      hw_upd = '{1'b1, 7'h03, 8'hff, 8'hff};
      @(negedge mclk);
      hw_upd = '0;
      repeat (2) @(negedge mclk);
      ev[0] = ev[0] | 8'hfc;
      ev[1] = ev[1] & 8'hdf;
      for (int i = 0; i < 3; i++)
         chk("hw update", ev[i], ctrl_bank[i]);
      $display("test hw_update done");
      pulse(0);
      for (int i = 0; i < 19; i++)
         chk("restart", ev[i] & tbl[i].keep, ctrl_bank[i]);
      $display("test restart done");
      @(negedge mclk);
      stat_set[0] = 8'hff;
      @(negedge mclk);
      stat_set[0] = 8'h00;
      pulse(1);
      for (int i = 0; i < 19; i++)
         chk("soft reset", 8'h00, ctrl_bank[i]);
      xf(1'b0, tbl[19].addr, 8'h00);
      chk("soft status", 8'h00, b2);
      chk("soft request", 8'h01, 8'(soft_reqs));
      $display("test soft_reset done");
      complete_run;
   end
endmodule // sbc_regbank_tb
